// File: rtl/gpio_settings_pkg.sv
// Constants for the GPIO readback and run-time settings command handler
// Behaviour
// - Read-GPIO reply echoes code 0x51 in byte 0, status 0x00 in byte 1.
// - Pin levels in bytes 2,4,6,8; 0xee when pin not in GPIO use.
// - Directions in bytes 3,5,7,9: 0 output, 1 input; 0xef otherwise.
// - Run-time settings are volatile; reset restores the defaults.
// - Settings command has code 0x60 in byte 0; byte 1 ignored.
// - Byte 2 bit 7 set loads bits 4..0 into the clock divider settings.
// - Byte 2 bits 4..3 give duty cycle 0, 25, 50 or 75 percent.
// - Byte 2 bits 2..0 are the divider value; bits 6..5 ignored.
// - Byte 3 bit 7 set loads bits 2..0 as DAC reference selection.
// - Byte 3 bits 2..1 set reference module level: off,1.024,2.048,4.096V.
// - Byte 3 bit 0 picks reference module (1) or supply rail (0).
// - Byte 4 bit 7 set loads bits 4..0 as new DAC value.
package gpio_settings_pkg;
  // ---------------------------------------------------------------
  // Report framing and codes
  // ---------------------------------------------------------------
  localparam int REPORT_LEN = 64;
  localparam logic [7:0] CMD_READ_GPIO = 8'h51;
  localparam logic [7:0] CMD_SET_RUNTIME = 8'h60;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] LEVEL_NOT_GPIO = 8'hee;
  localparam logic [7:0] DIR_NOT_GPIO = 8'hef;
  localparam logic [7:0] DIR_OUTPUT = 8'h00;
  localparam logic [7:0] DIR_INPUT = 8'h01;
  // ---------------------------------------------------------------
  // Command and reply byte positions and fields
  // ---------------------------------------------------------------
  localparam int BYTE_CLKOUT = 2;
  localparam int BYTE_DACREF = 3;
  localparam int BYTE_DACVAL = 4;
  localparam int BYTE_PIN_BASE = 2;
  localparam int LOAD_BIT = 7;
  // ---------------------------------------------------------------
  // Power-up defaults of the volatile copies
  // ---------------------------------------------------------------
  localparam logic [4:0] CLKOUT_RESET = 5'h00;
  localparam logic [2:0] DACREF_RESET = 3'h0;
  localparam logic [4:0] DACVAL_RESET = 5'h00;
endpackage : gpio_settings_pkg

// File: rtl/gpio_pin_report.sv
// One pin's level and direction bytes of the read-GPIO reply
`timescale 1ns/1ps
module gpio_pin_report (
  // Pin state
  input wire logic i_is_gpio,
  input wire logic i_level,
  input wire logic i_is_input,
  // Reply bytes
  output logic [7:0] o_level_byte,
  output logic [7:0] o_dir_byte
);
  // ---------------------------------------------------------------
  // Encoding
  // ---------------------------------------------------------------
  // level or marker
  assign o_level_byte = i_is_gpio ? {7'h00, i_level}
                                  : gpio_settings_pkg::LEVEL_NOT_GPIO;
  assign o_dir_byte = !i_is_gpio ? gpio_settings_pkg::DIR_NOT_GPIO
                    : (i_is_input ? gpio_settings_pkg::DIR_INPUT
                                  : gpio_settings_pkg::DIR_OUTPUT);
endmodule : gpio_pin_report

// File: rtl/gpio_settings_cmd.sv
// Command handler: read-GPIO reply and run-time settings loader
`timescale 1ns/1ps
module gpio_settings_cmd #(
  parameter int PINS = 4
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Command report in, one byte per cycle
  input wire logic i_cmd_valid,
  input wire logic i_cmd_first,
  input wire logic [7:0] i_cmd_byte,
  // Pin state
  input wire logic [PINS-1:0] i_pin_is_gpio,
  input wire logic [PINS-1:0] i_pin_level,
  input wire logic [PINS-1:0] i_pin_is_input,
  // Reply report out, one byte per cycle
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_byte,
  output logic o_rsp_last,
  // Run-time settings
  output logic [1:0] o_clkout_duty,
  output logic [2:0] o_clkout_div,
  output logic [1:0] o_vref_level,
  output logic o_dac_use_vref,
  output logic [4:0] o_dac_value
);
  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (PINS != 4) begin : g_bad_pins
    $error("PINS must be 4: the reply has four pin slots");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTINGS = 2'b01,
    ST_SKIP = 2'b10
  } cmd_state_t;

  cmd_state_t state;
  logic [5:0] in_idx;
  logic [5:0] out_idx;
  logic replying;
  logic [4:0] clkout;
  logic [2:0] dacref;
  logic [4:0] dacval;
  logic [7:0] lvl_b [PINS];
  logic [7:0] dir_b [PINS];
  logic [PINS-1:0] snap_gpio;
  logic [PINS-1:0] snap_lvl;
  logic [PINS-1:0] snap_in;
  logic [7:0] next_rsp;
  logic load_en;

  // Report end and pin slot range come from the shared constants
  localparam logic [5:0] LAST_IDX = 6'(gpio_settings_pkg::REPORT_LEN - 1);
  localparam logic [5:0] PIN_FIRST = 6'(gpio_settings_pkg::BYTE_PIN_BASE);
  localparam logic [5:0] PIN_LAST = 6'(gpio_settings_pkg::BYTE_PIN_BASE
                                       + 2 * PINS - 1);

  // ---------------------------------------------------------------
  // Command parser
  // ---------------------------------------------------------------
  // fixed 64-byte reports, index wraps at the end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_idx <= 6'h00;
    end else if (i_cmd_valid) begin
      in_idx <= i_cmd_first ? 6'h01 : in_idx + 6'h01;
    end
  end

  // dispatch on byte 0; other codes are skipped
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
    end else if (i_cmd_valid && i_cmd_first) begin
      state <= (i_cmd_byte == gpio_settings_pkg::CMD_SET_RUNTIME)
               ? ST_SETTINGS : ST_SKIP;
    end else if (i_cmd_valid && in_idx == LAST_IDX) begin
      state <= ST_IDLE;
    end
  end

  assign load_en = i_cmd_valid && !i_cmd_first && state == ST_SETTINGS
                   && i_cmd_byte[gpio_settings_pkg::LOAD_BIT];

  // ---------------------------------------------------------------
  // Volatile settings, restored only by reset
  // ---------------------------------------------------------------
  // reset defaults are constants; commands touch only copies
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clkout <= gpio_settings_pkg::CLKOUT_RESET;
    end else if (load_en && in_idx == 6'(gpio_settings_pkg::BYTE_CLKOUT)) begin
      clkout <= i_cmd_byte[4:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dacref <= gpio_settings_pkg::DACREF_RESET;
    end else if (load_en && in_idx == 6'(gpio_settings_pkg::BYTE_DACREF)) begin
      dacref <= i_cmd_byte[2:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dacval <= gpio_settings_pkg::DACVAL_RESET;
    end else if (load_en && in_idx == 6'(gpio_settings_pkg::BYTE_DACVAL)) begin
      dacval <= i_cmd_byte[4:0];
    end
  end

  assign o_clkout_duty = clkout[4:3];
  // divider field; bits 6..5 never stored
  assign o_clkout_div = clkout[2:0];
  assign o_vref_level = dacref[2:1];
  assign o_dac_use_vref = dacref[0];
  assign o_dac_value = dacval;

  // ---------------------------------------------------------------
  // Read-GPIO reply
  // ---------------------------------------------------------------
  // Pin state is frozen at the command so one reply is self-consistent
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      snap_gpio <= '0;
      snap_lvl <= '0;
      snap_in <= '0;
    end else if (i_cmd_valid && i_cmd_first
                 && i_cmd_byte == gpio_settings_pkg::CMD_READ_GPIO) begin
      snap_gpio <= i_pin_is_gpio;
      snap_lvl <= i_pin_level;
      snap_in <= i_pin_is_input;
    end
  end

  for (genvar p = 0; p < PINS; p++) begin : g_pin
    gpio_pin_report u_pin (
      .i_is_gpio(snap_gpio[p]),
      .i_level(snap_lvl[p]),
      .i_is_input(snap_in[p]),
      .o_level_byte(lvl_b[p]),
      .o_dir_byte(dir_b[p])
    );
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      replying <= 1'b0;
      out_idx <= 6'h00;
    end else if (i_cmd_valid && i_cmd_first
                 && i_cmd_byte == gpio_settings_pkg::CMD_READ_GPIO) begin
      replying <= 1'b1;
      out_idx <= 6'h00;
    end else if (replying) begin
      out_idx <= out_idx + 6'h01;
      if (out_idx == LAST_IDX) begin
        replying <= 1'b0;
      end
    end
  end

  // Byte mux for the current reply slot
  always_comb begin
    next_rsp = 8'h00;
    if (out_idx == 6'h00) begin
      next_rsp = gpio_settings_pkg::CMD_READ_GPIO;
    end else if (out_idx == 6'h01) begin
      next_rsp = gpio_settings_pkg::STATUS_OK;
    end else if (out_idx >= PIN_FIRST && out_idx <= PIN_LAST) begin
      if (out_idx[0]) begin
        next_rsp = dir_b[2'((out_idx - PIN_FIRST) >> 1)];
      end else begin
        next_rsp = lvl_b[2'((out_idx - PIN_FIRST) >> 1)];
      end
    end
  end

  // Data output registered; one reply byte per cycle after the command
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_byte <= 8'h00;
      o_rsp_last <= 1'b0;
    end else begin
      o_rsp_valid <= replying;
      o_rsp_byte <= replying ? next_rsp : 8'h00;
      o_rsp_last <= replying && out_idx == LAST_IDX;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_reply_code_echo: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_cmd_valid && i_cmd_first && i_cmd_byte == 8'h51)
    |-> ##2 (o_rsp_valid && o_rsp_byte == 8'h51)
        ##1 (o_rsp_valid && o_rsp_byte == 8'h00))
    else $error("read reply header wrong");

  a_level_marker: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (replying && out_idx == 6'h02 && !snap_gpio[0])
    |=> o_rsp_byte == 8'hee)
    else $error("pin 0 level marker wrong");

  a_dir_report: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (replying && out_idx == 6'h09)
    |=> o_rsp_byte == (!snap_gpio[3] ? 8'hef : {7'h00, snap_in[3]}))
    else $error("pin 3 direction byte wrong");

  a_div_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (state == ST_SETTINGS && i_cmd_valid && in_idx == 6'h02
     && !i_cmd_byte[7]) |=> $stable(clkout))
    else $error("divider changed without load bit");

  a_div_load: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (state == ST_SETTINGS && i_cmd_valid && !i_cmd_first && in_idx == 6'h02
     && i_cmd_byte[7]) |=> o_clkout_div == $past(i_cmd_byte[2:0])
        && o_clkout_duty == $past(i_cmd_byte[4:3]))
    else $error("divider load wrong");

  a_ref_load: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (state == ST_SETTINGS && i_cmd_valid && !i_cmd_first && in_idx == 6'h03
     && i_cmd_byte[7]) |=> {o_vref_level, o_dac_use_vref}
        == $past(i_cmd_byte[2:0]))
    else $error("DAC reference load wrong");

  a_dac_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_cmd_valid && in_idx == 6'h04 && !i_cmd_byte[7])
    |=> $stable(o_dac_value))
    else $error("DAC value changed without load bit");

  a_other_cmd_inert: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (state == ST_SKIP) |=> $stable(dacval) && $stable(clkout)
        && $stable(dacref))
    else $error("setting changed by another command");

  a_reply_length: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_rsp_valid) |-> ##63 o_rsp_last)
    else $error("reply not 64 bytes");
endmodule : gpio_settings_cmd

// File: verif/host_cmd_model.sv
// Host-side model that sends command reports of len bytes, byte by byte
`timescale 1ns/1ps
module host_cmd_model (
  // Clock
  input wire logic i_mclk,
  // Command stream
  output logic o_valid,
  output logic o_first,
  output logic [7:0] o_byte
);
  int seed = 32'h9f63;
  initial begin
    o_valid = 1'b0;
    o_first = 1'b0;
    o_byte = 8'h00;
  end
  task automatic send(input logic [7:0] code, input logic [7:0] b2,
      input logic [7:0] b3, input logic [7:0] b4, input int len,
      input int gap);
    logic [7:0] b;
    for (int n = 0; n < len; n++) begin
      case (n)
        0: b = code;
        2: b = b2;
        3: b = b3;
        4: b = b4;
        default: b = 8'($random(seed));
      endcase
      o_valid <= 1'b1;
      o_first <= (n == 0);
      o_byte <= b;
      @(posedge i_mclk);
      // Idle lane flips so nothing can lean on the last byte
      if (gap > 0) begin
        o_valid <= 1'b0;
        o_byte <= ~b;
        repeat (gap) @(posedge i_mclk);
      end
    end
    o_valid <= 1'b0;
    o_first <= 1'b0;
    o_byte <= ~b;
  endtask : send
endmodule : host_cmd_model

// File: verif/tb.sv
// Self-checking bench for the GPIO readback and settings handler
`timescale 1ns/1ps
module tb;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] pin_gpio = 4'h0;
  logic [3:0] pin_level = 4'h0;
  logic [3:0] pin_input = 4'h0;
  logic cmd_valid;
  logic cmd_first;
  logic [7:0] cmd_byte;
  logic rsp_valid;
  logic rsp_last;
  logic [7:0] rsp_byte;
  logic [1:0] duty;
  logic [2:0] div;
  logic [1:0] level;
  logic use_vref;
  logic [4:0] dac;
  logic [1:0] m_duty = 2'h0;
  logic [2:0] m_div = 3'h0;
  logic [1:0] m_level = 2'h0;
  logic m_vref = 1'h0;
  logic [4:0] m_dac = 5'h00;
  logic [7:0] code = 8'h00;
  logic [31:0] r;
  logic [7:0] exp_q[$];
  logic [7:0] got_q[$];
  int seed = 32'h9f63;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  int idx = 0;
  int n_rsp_exp = 0;
  int n_rsp_got = 0;

  gpio_settings_cmd uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_cmd_valid(cmd_valid), .i_cmd_first(cmd_first),
    .i_cmd_byte(cmd_byte), .i_pin_is_gpio(pin_gpio),
    .i_pin_level(pin_level), .i_pin_is_input(pin_input),
    .o_rsp_valid(rsp_valid), .o_rsp_byte(rsp_byte),
    .o_rsp_last(rsp_last), .o_clkout_duty(duty), .o_clkout_div(div),
    .o_vref_level(level), .o_dac_use_vref(use_vref), .o_dac_value(dac));
  host_cmd_model host (.i_mclk(i_mclk), .o_valid(cmd_valid),
    .o_first(cmd_first), .o_byte(cmd_byte));

  always #5 i_mclk = ~i_mclk;

  task automatic check(input string name, input logic [7:0] seen,
      input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // Pins wander every cycle; the timeout cuts a hang short
  always @(posedge i_mclk) begin
    pin_gpio <= 4'($random(seed));
    pin_level <= 4'($random(seed));
    pin_input <= 4'($random(seed));
    cycles++;
    if (cycles == 10000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // Reference model of the command stream
  // ---------------------------------------------------------------
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {m_duty, m_div, m_level, m_vref, m_dac} = 13'h0000;
      idx = 0;
      got_q.delete();
    end else if (cmd_valid) begin
      idx = cmd_first ? 0 : idx + 1;
      if (cmd_first)
        code = cmd_byte;
      if (code == 8'h60 && idx == 2 && cmd_byte[7])
        {m_duty, m_div} = cmd_byte[4:0];
      if (code == 8'h60 && idx == 3 && cmd_byte[7])
        {m_level, m_vref} = cmd_byte[2:0];
      if (code == 8'h60 && idx == 4 && cmd_byte[7])
        m_dac = cmd_byte[4:0];
      // reply from pins at this edge
      if (cmd_first && cmd_byte == 8'h51) begin
        n_rsp_exp++;
        exp_q = {8'h51, 8'h00};
        for (int p = 0; p < 4; p++) begin
          exp_q.push_back(pin_gpio[p] ? {7'h00, pin_level[p]} : 8'hee);
          exp_q.push_back(pin_gpio[p] ? {7'h00, pin_input[p]} : 8'hef);
        end
        while (exp_q.size() < 64)
          exp_q.push_back(8'h00);
      end
    end
  end

  // ---------------------------------------------------------------
  // Compare at every falling edge, outputs settled
  // ---------------------------------------------------------------
  always @(negedge i_mclk) begin
    check("clkout_div", {5'h00, div}, {5'h00, m_div});
    check("clkout_duty", {6'h00, duty}, {6'h00, m_duty});
    check("vref_level", {6'h00, level}, {6'h00, m_level});
    check("use_vref", {7'h00, use_vref}, {7'h00, m_vref});
    check("dac_value", {3'h0, dac}, {3'h0, m_dac});
    if (rsp_valid) begin
      got_q.push_back(rsp_byte);
      // A missing end marker must not let the reply go unchecked
      check("rsp_last", 8'(rsp_last), 8'(got_q.size() == 64));
      if (rsp_last) begin
        n_rsp_got++;
        check("rsp_len", 8'(got_q.size()), 8'h40);
        for (int k = 0; k < 64; k++) begin
          check("rsp_byte", got_q[k], exp_q[k]);
        end
        got_q.delete();
      end
    end else begin
      check("rsp_idle", rsp_byte, 8'h00);
      check("rsp_last", 8'(rsp_last), 8'h00);
    end
  end

  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    // Every duty and reference code loaded; odd gaps; one foreign code
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      host.send(i == 5 ? 8'h61 : 8'h60, {i[0], r[6:5], i[2:1], r[2:0]},
        {i[3] | i[0], r[14:11], i[2:0]}, {i[3] | i[0], r[22:16]},
        64, i % 3);
      @(posedge i_mclk);
    end
    // Cut-short report, then restarts by new first bytes
    host.send(8'h60, 8'h9a, 8'h87, 8'h9f, 3, 0);
    @(posedge i_mclk);
    repeat (6) begin
      host.send(8'h51, 8'h00, 8'h00, 8'h00, 64, 0);
      repeat (4) @(posedge i_mclk);
    end
    // A second reset must bring back the defaults
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    host.send(8'h51, 8'h00, 8'h00, 8'h00, 64, 1);
    repeat (8) @(posedge i_mclk);
    check("replies", 8'(n_rsp_got), 8'(n_rsp_exp));
    wrap_up();
  end
endmodule : tb
